// file: pkg/ics_params.svh
/*
 constants for the inductive sensor conversion setup block: register
 offsets, field positions, reset values and timing counts.
 assumes inclusion by bare name from the package and verification files.
*/
`ifndef ICS_PARAMS_SVH
`define ICS_PARAMS_SVH

// ------------------------------------------------------------
// register indexes (printed offsets) and byte addresses
// ------------------------------------------------------------
`define ICS_IDX_MAIN 8'h1a
`define ICS_IDX_SCAN 8'h1b
`define ICS_IDX_RST 8'h1c
`define ICS_IDX_STAT 8'h1d
`define ICS_ADDR_MAIN 12'h068
`define ICS_ADDR_SCAN 12'h06c
`define ICS_ADDR_RST 12'h070
`define ICS_ADDR_STAT 12'h074

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ICS_MAIN_CHAN_HI 15
`define ICS_MAIN_CHAN_LO 14
`define ICS_MAIN_SLEEP 13
`define ICS_MAIN_OVR 12
`define ICS_MAIN_STYLE 11
`define ICS_MAIN_AMPOFF 10
`define ICS_MAIN_REFSRC 9
`define ICS_MAIN_IRQMSK 7
`define ICS_MAIN_BOOST 6
`define ICS_SCAN_ON 15
`define ICS_SCAN_ORD_HI 14
`define ICS_SCAN_ORD_LO 13
`define ICS_SCAN_DG_HI 2
`define ICS_RST_BIT 15
`define ICS_RST_GAIN_HI 10
`define ICS_RST_GAIN_LO 9

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define ICS_MAIN_RESET 16'h2801
`define ICS_SCAN_RESET 16'h020f
`define ICS_RST_RESET 16'h0000

// ------------------------------------------------------------
// timing: one conversion slot per channel
// ------------------------------------------------------------
`define ICS_SLOT_NS 1000
`define ICS_CLK_NS 50
`define ICS_SLOT_CYC ((`ICS_SLOT_NS + `ICS_CLK_NS - 1) / `ICS_CLK_NS)
`define ICS_SRST_CYC 4

`endif

// file: pkg/ics_pkg.sv
/*
 types for the inductive sensor conversion setup block.
 assumes ics_params.svh is on the include path.
*/
package ics_pkg;
   `include "ics_params.svh"

   typedef enum logic [1:0] {ICS_RUN, ICS_SRST} ics_state_e;

   // apb request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ics_apb_req_s;

   // apb answer to the master
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ics_apb_rsp_s;

   // steering outputs toward the analog front end
   typedef struct packed {
      logic [1:0] conv_channel;
      logic sleep;
      logic drive_current_override;
      logic startup_drive_style;
      logic amplitude_correction_off;
      logic reference_source_pick;
      logic boosted_drive;
      logic [2:0] deglitch_sel;
      logic [2:0] gain_shift;
   } ics_ctl_s;
endpackage

// file: verilog/ics_seq.sv
/*
 channel sequencer: steps the converted channel once per slot.
 assumes a single clock and the synchronised active-low reset.
*/
`timescale 1ns/1ps
module ics_seq #(
   parameter int SLOT_CYC = 20
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rstn,
   // control
   input wire logic i_run,
   input wire logic i_scan,
   input wire logic [1:0] i_order,
   input wire logic [1:0] i_single,
   input wire logic i_four_ch,
   // status
   output logic [1:0] o_chan,
   output logic o_slot_end
);
   import ics_pkg::*;

   typedef struct packed {
      logic [15:0] cnt;
      logic [1:0] chan;
      logic slot_end;
   } ics_seq_s;

   ics_seq_s st_ff;
   ics_seq_s nxt_st;
   logic [1:0] last;
   logic [1:0] single;

   always_comb begin
      // last channel of the round-robin order
      case (i_order)
         2'h1: last = i_four_ch ? 2'h2 : 2'h1; // see R13
         2'h2: last = i_four_ch ? 2'h3 : 2'h1; // see R13
         default: last = 2'h1; // see R13
      endcase
      // two-channel part folds codes 10 and 11 down to channel 1
      single = (i_four_ch || !i_single[1]) ? i_single : 2'h1; // see R02
      nxt_st = st_ff;
      nxt_st.slot_end = 1'b0;
      if (!i_run) begin
         nxt_st.cnt = 16'h0000;
         nxt_st.chan = i_scan ? 2'h0 : single;
      end else if (st_ff.cnt == 16'(SLOT_CYC - 1)) begin
         nxt_st.cnt = 16'h0000;
         nxt_st.slot_end = 1'b1;
         if (!i_scan) begin
            nxt_st.chan = single; // see R01
         end else if (st_ff.chan >= last) begin
            nxt_st.chan = 2'h0; // see R13
         end else begin
            nxt_st.chan = st_ff.chan + 2'h1; // see R12
         end
      end else begin
         nxt_st.cnt = st_ff.cnt + 16'h0001;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_chan = st_ff.chan;
   assign o_slot_end = st_ff.slot_end;

   AST_SCAN_WRAP: assert property (@(posedge i_mclk) disable iff (!i_rstn) // see R13
      (i_run && i_scan && o_slot_end && o_chan == 2'h0) |-> $past(o_chan) != 2'h0
         || !$past(i_run) || !$past(i_scan))
      else $error("scan restarted without stepping");
endmodule

// file: verilog/ics_top.sv
/*
 inductive sensor conversion setup: apb register file holding the main
 setup, channel scan setup and soft reset/gain registers, channel
 sequencing, irq pin gating and output gain shift.
 assumes an apb master on i_mclk and a conversion datapath that
 reports status updates and amplitude-correction phase ends.
*/
// The APB slave port was chosen for this implementation.
// Operation
// R01: without scan, convert continuously on the single picked channel.
// R02: channels 2 and 3 exist only on the four-channel variant.
// R03: sleep bit set means sleep; resets to 1, so device starts asleep.
// R04: override bit set drives each channel with its programmed level.
// R05: activation style 0 uses maximum drive for short activation.
// R06: activation style 1 (default) uses programmed drive during activation.
// R07: amplitude correction off stops algorithm and freezes measured drive.
// R08: reference source 0 internal oscillator, 1 external reference pin.
// R09: irq mask 0 asserts irq pin on status update; 1 holds it high.
// R10: boosted drive 1 drives channel 0 above normal current.
// R11: host must not combine boosted drive with scanning.
// R12: scan bit 0 single channel, 1 sequenced conversion.
// R13: scan orders: 00/11 ch0-1, 01 ch0-2, 10 ch0-3, repeating.
// R14: deglitch field sets bandwidth; reset value 111.
// R15: host should pick lowest deglitch above sensor frequency.
// R16: writing 1 to soft reset resets the device; reads back 0.
// R17: gain code shifts output left by 0, 2, 3 or 4 bits.
// R18: host writes main setup low six bits as 000001.
// R19: host writes scan setup bits 12:3 as 0001000001.
// R20: host writes zero to main bit 8 and reset bits 14:11.
// R21: measured start drive refreshes only while correction is enabled.
// R22: soft reset restores all fields to reset values like power-on.
`timescale 1ns/1ps
module ics_top #(
   parameter bit FOUR_CH = 1'b1,
   parameter int DATA_W = 12
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_resetn,
   // apb slave
   input wire ics_pkg::ics_apb_req_s i_apb,
   output ics_pkg::ics_apb_rsp_s o_apb,
   // datapath events
   input wire logic i_status_update,
   input wire logic i_amp_phase_done,
   input wire logic [4:0] i_amp_measured,
   input wire logic [DATA_W-1:0] i_conv_data,
   input wire logic i_conv_valid,
   // front-end steering
   output ics_pkg::ics_ctl_s o_ctl,
   output logic [3:0] o_chan_onehot,
   output logic o_slot_end,
   output logic [4:0] o_measured_start_drive,
   output logic [DATA_W+3:0] o_gained_data,
   output logic o_gained_valid,
   output logic o_irq_pin_n
);
   import ics_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0] main_setup;
      logic [15:0] scan_setup;
      logic [1:0] gain;
      ics_state_e state;
      logic [2:0] srst_cnt;
      logic [4:0] meas;
      logic irq_n;
      ics_apb_rsp_s rsp;
      ics_ctl_s ctl;
      logic [3:0] onehot;
      logic slot_end;
      logic [DATA_W+3:0] gdata;
      logic gvalid;
   } ics_top_s;

   ics_top_s st_ff;
   ics_top_s nxt_st;
   logic rst_meta_ff;
   logic rst_sync_ff;
   logic [1:0] seq_chan;
   logic seq_slot_end;
   logic wr_acc;
   logic [2:0] shift;

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   ics_seq #(
      .SLOT_CYC(`ICS_SLOT_CYC)
   ) u_seq (
      .i_mclk(i_mclk),
      .i_rstn(rst_sync_ff),
      .i_run(!st_ff.main_setup[`ICS_MAIN_SLEEP] && st_ff.state == ICS_RUN),
      .i_scan(st_ff.scan_setup[`ICS_SCAN_ON]),
      .i_order(st_ff.scan_setup[`ICS_SCAN_ORD_HI:`ICS_SCAN_ORD_LO]),
      .i_single(st_ff.main_setup[`ICS_MAIN_CHAN_HI:`ICS_MAIN_CHAN_LO]),
      .i_four_ch(FOUR_CH),
      .o_chan(seq_chan),
      .o_slot_end(seq_slot_end)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   assign wr_acc = i_apb.psel && i_apb.penable && i_apb.pwrite;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.rsp.pready = 1'b0;
      nxt_st.rsp.pslverr = 1'b0;
      nxt_st.slot_end = seq_slot_end;
      case (st_ff.state)
         ICS_SRST: begin
            // bus held off until all fields are back at reset values
            nxt_st.main_setup = `ICS_MAIN_RESET; // see R22
            nxt_st.scan_setup = `ICS_SCAN_RESET; // see R22
            nxt_st.gain = 2'h0;
            nxt_st.meas = 5'h00;
            if (st_ff.srst_cnt == 3'h0) begin
               nxt_st.state = ICS_RUN;
            end else begin
               nxt_st.srst_cnt = st_ff.srst_cnt - 3'h1;
            end
         end
         default: begin
            // setup cycle answers one cycle later in the access phase; an access
            // whose setup fell in the soft reset hold is answered once back in run
            if (i_apb.psel && (!i_apb.penable || !st_ff.rsp.pready)) begin
               nxt_st.rsp.pready = 1'b1;
               nxt_st.rsp.prdata = 32'h0000_0000;
               case (i_apb.paddr)
                  `ICS_ADDR_MAIN: nxt_st.rsp.prdata = {16'h0000, st_ff.main_setup};
                  `ICS_ADDR_SCAN: nxt_st.rsp.prdata = {16'h0000, st_ff.scan_setup};
                  // soft reset bit always reads back 0
                  `ICS_ADDR_RST: nxt_st.rsp.prdata = {21'h0, st_ff.gain, 9'h0}; // see R16
                  `ICS_ADDR_STAT: nxt_st.rsp.prdata = {25'h0, st_ff.meas, seq_chan};
                  default: nxt_st.rsp.pslverr = 1'b1;
               endcase
            end
            if (wr_acc && st_ff.rsp.pready) begin
               case (i_apb.paddr)
                  `ICS_ADDR_MAIN: nxt_st.main_setup = i_apb.pwdata[15:0]; // see R03
                  `ICS_ADDR_SCAN: nxt_st.scan_setup = i_apb.pwdata[15:0]; // see R12
                  `ICS_ADDR_RST: begin
                     nxt_st.gain = i_apb.pwdata[`ICS_RST_GAIN_HI:`ICS_RST_GAIN_LO];
                     if (i_apb.pwdata[`ICS_RST_BIT]) begin
                        nxt_st.state = ICS_SRST; // see R16
                        nxt_st.srst_cnt = 3'(`ICS_SRST_CYC - 1);
                     end
                  end
                  default: nxt_st.state = st_ff.state;
               endcase
            end
            // measured drive frozen while correction is off
            if (i_amp_phase_done && !st_ff.main_setup[`ICS_MAIN_AMPOFF]) begin
               nxt_st.meas = i_amp_measured; // see R21 R07
            end
         end
      endcase
      // front-end steering
      nxt_st.ctl.conv_channel = seq_chan; // see R01
      nxt_st.ctl.sleep = st_ff.main_setup[`ICS_MAIN_SLEEP]; // see R03
      nxt_st.ctl.drive_current_override = st_ff.main_setup[`ICS_MAIN_OVR]; // see R04
      nxt_st.ctl.startup_drive_style = st_ff.main_setup[`ICS_MAIN_STYLE]; // see R05 R06
      nxt_st.ctl.amplitude_correction_off = st_ff.main_setup[`ICS_MAIN_AMPOFF]; // see R07
      nxt_st.ctl.reference_source_pick = st_ff.main_setup[`ICS_MAIN_REFSRC]; // see R08
      // boost only reaches channel 0
      nxt_st.ctl.boosted_drive = st_ff.main_setup[`ICS_MAIN_BOOST] && seq_chan == 2'h0; // see R10
      nxt_st.ctl.deglitch_sel = st_ff.scan_setup[`ICS_SCAN_DG_HI:0]; // see R14
      case (st_ff.gain)
         2'h1: shift = 3'h2;
         2'h2: shift = 3'h3;
         2'h3: shift = 3'h4;
         default: shift = 3'h0;
      endcase
      nxt_st.ctl.gain_shift = shift; // see R17
      nxt_st.onehot = 4'h1 << seq_chan;
      // output field is four bits wider than the data, so no shift loses upper bits
      nxt_st.gdata = (DATA_W + 4)'(i_conv_data) << shift; // see R17
      nxt_st.gvalid = i_conv_valid;
      // irq pin pulses low for one cycle per status update while the irq mask bit is 0
      nxt_st.irq_n = !(i_status_update && !st_ff.main_setup[`ICS_MAIN_IRQMSK]); // see R09
   end

   always_ff @(posedge i_mclk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         st_ff <= '0;
         st_ff.main_setup <= `ICS_MAIN_RESET;
         st_ff.scan_setup <= `ICS_SCAN_RESET;
         st_ff.state <= ICS_RUN;
         st_ff.irq_n <= 1'b1;
         st_ff.ctl.sleep <= 1'b1;
         st_ff.ctl.startup_drive_style <= 1'b1;
         st_ff.ctl.deglitch_sel <= 3'h7;
         st_ff.onehot <= 4'h1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign o_apb = st_ff.rsp;
   assign o_ctl = st_ff.ctl;
   assign o_chan_onehot = st_ff.onehot;
   assign o_slot_end = st_ff.slot_end;
   assign o_measured_start_drive = st_ff.meas;
   assign o_gained_data = st_ff.gdata;
   assign o_gained_valid = st_ff.gvalid;
   assign o_irq_pin_n = st_ff.irq_n;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_srst_write;
      wr_acc && o_apb.pready && i_apb.paddr == `ICS_ADDR_RST && i_apb.pwdata[`ICS_RST_BIT];
   endsequence
   sequence s_back_to_reset;
      ##[1:8] (st_ff.main_setup == `ICS_MAIN_RESET && st_ff.scan_setup == `ICS_SCAN_RESET);
   endsequence

   AST_SRST_RESTORES: assert property (@(posedge i_mclk) disable iff (!rst_sync_ff) // see R22
      s_srst_write |-> s_back_to_reset)
      else $error("soft reset did not restore fields");
   AST_SRST_READS_ZERO: assert property (@(posedge i_mclk) disable iff (!rst_sync_ff) // see R16
      (o_apb.pready && i_apb.paddr == `ICS_ADDR_RST) |-> !o_apb.prdata[`ICS_RST_BIT])
      else $error("soft reset bit read as one");
   AST_IRQ_MASKED: assert property (@(posedge i_mclk) disable iff (!rst_sync_ff) // see R09
      $past(st_ff.main_setup[`ICS_MAIN_IRQMSK]) |-> o_irq_pin_n)
      else $error("irq pin low while masked");
   AST_IRQ_FIRES: assert property (@(posedge i_mclk) disable iff (!rst_sync_ff) // see R09
      (i_status_update && !st_ff.main_setup[`ICS_MAIN_IRQMSK]) |=> !o_irq_pin_n)
      else $error("irq pin missed a status update");
   AST_MEAS_FROZEN: assert property (@(posedge i_mclk) disable iff (!rst_sync_ff) // see R07
      (st_ff.main_setup[`ICS_MAIN_AMPOFF] && st_ff.state == ICS_RUN) |=> $stable(st_ff.meas))
      else $error("measured drive moved while correction off");
   AST_MEAS_REFRESH: assert property (@(posedge i_mclk) disable iff (!rst_sync_ff) // see R21
      (i_amp_phase_done && !st_ff.main_setup[`ICS_MAIN_AMPOFF] && st_ff.state == ICS_RUN)
         |=> st_ff.meas == $past(i_amp_measured))
      else $error("measured drive not refreshed");
   // the sequencer takes its pick one cycle before its slot end shows
   AST_SINGLE_CHAN: assert property (@(posedge i_mclk) disable iff (!rst_sync_ff) // see R01
      (seq_slot_end && !$past(st_ff.scan_setup[`ICS_SCAN_ON]) && FOUR_CH)
         |-> seq_chan == $past(st_ff.main_setup[`ICS_MAIN_CHAN_HI:`ICS_MAIN_CHAN_LO]))
      else $error("single mode left the picked channel");
   AST_TWO_CH_LIMIT: assert property (@(posedge i_mclk) disable iff (!rst_sync_ff) // see R02
      !FOUR_CH |-> seq_chan[1] == 1'b0)
      else $error("absent channel selected");
   AST_BOOST_CH0: assert property (@(posedge i_mclk) disable iff (!rst_sync_ff) // see R10
      o_ctl.boosted_drive |-> $past(seq_chan) == 2'h0)
      else $error("boost on a channel other than 0");
   AST_GAIN_SHIFT: assert property (@(posedge i_mclk) disable iff (!rst_sync_ff) // see R17
      (st_ff.gain == 2'h1) |=> o_ctl.gain_shift == 3'h2)
      else $error("gain code 01 not a two bit shift");
endmodule

// file: verif/ics_host_model.sv
/*
 host model: apb master that issues one transfer at a time.
 assumes the slave answers with pready at a rising edge of i_mclk.
*/
`timescale 1ns/1ps
`include "ics_params.svh"
module ics_host_model (
   // clock
   input wire logic i_mclk,
   // apb answer
   input wire ics_pkg::ics_apb_rsp_s i_rsp,
   // apb request
   output ics_pkg::ics_apb_req_s o_req
);
   import ics_pkg::*;
   logic hung;
   initial begin
      o_req = '0;
      hung = 1'b0;
   end
   // ------------------------------------------------------------
   // one transfer: setup, access until pready, then release
   // ------------------------------------------------------------
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      int n;
      logic [31:0] dd;
      dd = d;
      // reserved bits always written with their fixed pattern
      if (a == `ICS_ADDR_MAIN) dd = {d[31:9], 1'b0, d[7:6], 6'h01};
      if (a == `ICS_ADDR_SCAN) dd[12:3] = 10'h041;
      if (a == `ICS_ADDR_RST) dd[14:11] = 4'h0;
      @(posedge i_mclk);
      o_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: dd};
      @(posedge i_mclk);
      o_req.penable <= 1'b1;
      n = 0;
      // soft reset stretches the access, so wait on pready, bounded
      do begin
         @(posedge i_mclk);
         n++;
      end while (i_rsp.pready !== 1'b1 && n < 40);
      q = i_rsp.prdata;
      e = i_rsp.pslverr;
      hung = (n >= 40);
      o_req <= '0;
   endtask
endmodule

// file: verif/inductive_sensor_conversion_setup_tb.sv
/*
 self-checking bench for ics_top: register, steering, scan, irq,
 amplitude freeze, gain and soft reset checks through apb.
 assumes ics_host_model as the apb master and the default four channels.
*/
`timescale 1ns/1ps
`include "ics_params.svh"
module inductive_sensor_conversion_setup_tb;
   import ics_pkg::*;
   logic i_mclk;
   logic i_resetn;
   ics_apb_req_s req;
   ics_apb_rsp_s rsp;
   logic upd, amp_done, cv;
   logic [4:0] amp_val;
   logic [11:0] cdata;
   ics_ctl_s ctl;
   logic [3:0] onehot;
   logic [4:0] msd;
   logic [15:0] gdata;
   logic gvalid, irq_n;
   int bad_count, checked;
   logic [1:0] mx, mx2;
   logic se;
   int ns;
   ics_apb_rsp_s rsp_two;
   ics_ctl_s ctl_two;
   logic [4:0] sh [4] = '{5'd0, 5'd2, 5'd3, 5'd4};
   logic [1:0] last [4] = '{2'd1, 2'd2, 2'd3, 2'd1};
   ics_top dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_apb(req), .o_apb(rsp),
      .i_status_update(upd), .i_amp_phase_done(amp_done), .i_amp_measured(amp_val),
      .i_conv_data(cdata), .i_conv_valid(cv), .o_ctl(ctl), .o_chan_onehot(onehot),
      .o_slot_end(se), .o_measured_start_drive(msd), .o_gained_data(gdata),
      .o_gained_valid(gvalid), .o_irq_pin_n(irq_n));
   // two-channel variant on the same bus; only its steering is watched
   ics_top #(.FOUR_CH(1'b0)) dut_two (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_apb(req),
      .o_apb(rsp_two), .i_status_update(upd), .i_amp_phase_done(amp_done),
      .i_amp_measured(amp_val), .i_conv_data(cdata), .i_conv_valid(cv), .o_ctl(ctl_two),
      .o_chan_onehot(), .o_slot_end(), .o_measured_start_drive(), .o_gained_data(),
      .o_gained_valid(), .o_irq_pin_n());
   ics_host_model host (.i_mclk(i_mclk), .i_rsp(rsp), .o_req(req));
   initial begin
      i_mclk = 1'b0;
      forever #25 i_mclk = ~i_mclk;
   end
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic xf(input logic w, input logic [11:0] a, input logic [15:0] d,
                     output logic [31:0] q, output logic e);
      host.xfer(w, a, {16'h0000, d}, q, e);
      if (host.hung) begin
         bad_count++;
         wrap_up();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      logic [31:0] q;
      logic e;
      xf(1'b1, a, d, q, e);
      repeat (3) @(posedge i_mclk);
   endtask
   task automatic rdc(input string nm, input logic [11:0] a, input logic [15:0] exp);
      logic [31:0] q;
      logic e;
      xf(1'b0, a, 16'h0000, q, e);
      chk(nm, q, {16'h0000, exp});
   endtask
   // m picks {status update, amp phase done, conv valid}; a is the measured drive
   task automatic pulse(input logic [2:0] m, input logic [4:0] a);
      @(posedge i_mclk);
      {upd, amp_done, cv} <= m;
      amp_val <= a;
      @(posedge i_mclk);
      {upd, amp_done, cv} <= 3'b000;
      @(negedge i_mclk);
   endtask
   function automatic logic [5:0] flags();
      return {ctl.sleep, ctl.drive_current_override, ctl.startup_drive_style,
              ctl.amplitude_correction_off, ctl.reference_source_pick, ctl.boosted_drive};
   endfunction
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] q;
      logic e;
      i_resetn = 1'b0;
      {upd, amp_done, cv} = 3'b000;
      amp_val = 5'h00;
      cdata = 12'h000;
      bad_count = 0;
      checked = 0;
      repeat (10) @(posedge i_mclk);
      i_resetn <= 1'b1;
      repeat (3) @(posedge i_mclk);
      chk("ctl flags", flags(), 6'b101000);
      rdc("main reset", `ICS_ADDR_MAIN, `ICS_MAIN_RESET);
      rdc("scan reset", `ICS_ADDR_SCAN, `ICS_SCAN_RESET);
      rdc("rst reset", `ICS_ADDR_RST, `ICS_RST_RESET);
      xf(1'b0, 12'h080, 16'h0000, q, e);
      chk("unmapped err", e, 1);
      chk("unmapped data", q, 0);
      $display("test reset done");
      wr(`ICS_ADDR_MAIN, 16'h1641);
      chk("ctl flags", flags(), 6'b010111);
      rdc("main back", `ICS_ADDR_MAIN, 16'h1641);
      for (int c = 0; c < 4; c++) begin
         wr(`ICS_ADDR_MAIN, {c[1:0], 14'h0801});
         repeat (25) @(posedge i_mclk);
         chk("single chan", ctl.conv_channel, c);
         chk("onehot", onehot, 4'h1 << c);
         chk("two-ch chan", ctl_two.conv_channel, c[1] ? 1 : c);
      end
      $display("test single done");
      // boosted drive stays off while scanning
      wr(`ICS_ADDR_MAIN, 16'h0801);
      for (int o = 0; o < 4; o++) begin
         wr(`ICS_ADDR_SCAN, {1'b1, o[1:0], 13'h020f});
         repeat (40) @(posedge i_mclk);
         mx = 2'd0;
         mx2 = 2'd0;
         ns = 0;
         repeat (300) begin
            @(negedge i_mclk);
            if (ctl.conv_channel > mx) mx = ctl.conv_channel;
            if (ctl_two.conv_channel > mx2) mx2 = ctl_two.conv_channel;
            if (se === 1'b1) ns++;
         end
         chk("scan top chan", mx, last[o]);
         chk("two-ch scan top", mx2, 1);
         // slots are periodic, so a 300-cycle window holds a whole number of them
         chk("slot count", ns, 300 / `ICS_SLOT_CYC);
      end
      $display("test scan done");
      for (int g = 0; g < 4; g++) begin
         wr(`ICS_ADDR_SCAN, {13'h0041, (g == 0 ? 3'h1 : g == 1 ? 3'h4 : g == 2 ? 3'h5 : 3'h7)});
         chk("deglitch", ctl.deglitch_sel, g == 0 ? 1 : g == 1 ? 4 : g == 2 ? 5 : 7);
      end
      for (int g = 0; g < 4; g++) begin
         wr(`ICS_ADDR_RST, {5'h00, g[1:0], 9'h000});
         cdata <= 12'hb5d;
         pulse(3'b001, 5'h00);
         chk("gain valid", gvalid, 1);
         chk("gain data", gdata, 16'hb5d << sh[g]);
         chk("gain shift", ctl.gain_shift, sh[g]);
      end
      $display("test gain done");
      pulse(3'b100, 5'h00);
      chk("irq low", irq_n, 0);
      wr(`ICS_ADDR_MAIN, 16'h0881);
      pulse(3'b100, 5'h00);
      chk("irq masked", irq_n, 1);
      pulse(3'b010, 5'h15);
      repeat (3) @(negedge i_mclk);
      chk("measured", msd, 5'h15);
      wr(`ICS_ADDR_MAIN, 16'h0c81);
      pulse(3'b010, 5'h0a);
      repeat (3) @(negedge i_mclk);
      chk("frozen", msd, 5'h15);
      rdc("status", `ICS_ADDR_STAT, 16'h0054);
      $display("test irq amp done");
      // the next read lands inside the soft reset hold and must wait it out
      xf(1'b1, `ICS_ADDR_RST, 16'h8000, q, e);
      rdc("rst readback", `ICS_ADDR_RST, 16'h0000);
      rdc("main after srst", `ICS_ADDR_MAIN, `ICS_MAIN_RESET);
      rdc("scan after srst", `ICS_ADDR_SCAN, `ICS_SCAN_RESET);
      chk("ctl after srst", flags(), 6'b101000);
      $display("test soft reset done");
      wrap_up();
   end
endmodule
